// ===== src/nfs_host.sv
// host controller issuing set-features and get-features on a nand target
// How it works
// RULE1 - send set code, address, four parameters
// RULE2 - send get code and address, then read
// RULE3 - settings persist across soft reset command
// RULE4 - known feature addresses; others are reserved
// RULE5 - ecc switched by first parameter at 90h
// RULE6 - array mode uses only first parameter
// RULE7 - array mode bits clear on power cycle
// RULE8 - issue commands only while target ready; the reset command from NFS_POR goes out without checking RB_N
// RULE9 - set code selects set mode
// RULE10 - wait address-to-param delay, one byte per strobe
// RULE11 - wait busy after fourth parameter
// RULE12 - interface change busy covered by ready wait
// RULE13 - get code selects get mode
// RULE14 - busy after get address; no status poll
// RULE15 - read four parameter bytes in order
// RULE16 - timing mode in bits 2:0
// RULE17 - drive strength in bits 1:0
// RULE18 - reset target first, then allow features
// RULE19 - reserved bits and bytes sent as zero
`timescale 1ns/1ns
`include "nfs_regs.svh"
module nfs_host (
   input wire logic REF_CLK,          // 250 MHz reference clock
   input wire logic RST_N,            // synchronous reset, active low
   input wire logic START,            // request, taken while READY
   input wire logic GET,              // 1 get-features, 0 set-features
   input wire logic [7:0] FEAT_ADDR,  // feature address
   input wire logic [7:0] PARAM1,     // first parameter for set
   output logic READY,                // controller idle and target ready
   output logic DONE,                 // one-cycle completion pulse
   output logic [31:0] RDATA,         // parameters read, first byte low
   output logic CE_N,                 // chip enable, active low
   output logic CLE,                  // command latch enable
   output logic ALE,                  // address latch enable
   output logic WE_N,                 // write strobe, active low
   output logic RE_N,                 // read strobe, active low
   output logic [7:0] IO_OUT,         // data bus driven value
   input wire logic [7:0] IO_IN,      // data bus sampled value
   output logic IO_OE_N,              // low while driving the bus
   input wire logic RB_N              // ready high, busy low
);

   nfs_pkg::nfs_host_t s_reg;
   nfs_pkg::nfs_host_t s_next;
   logic tmr_done;
   logic wr_state;
   logic in_adl;

   // reserved bits are cleared so the target never sees stray ones
   function automatic logic [7:0] nfs_mask(input logic [7:0] addr, input logic [7:0] p);
      case (addr)
         // RULE16 timing mode field
         `NFS_FA_TIMING: nfs_mask = p & `NFS_TIMING_MASK;
         // RULE17 drive strength field
         `NFS_FA_DRIVE: nfs_mask = p & `NFS_DRIVE_MASK;
         `NFS_FA_PULLDN: nfs_mask = p & `NFS_PULLDN_MASK;
         // RULE5 ecc and otp bits
         `NFS_FA_ARRAY: nfs_mask = p & `NFS_ARRAY_MASK;
         // RULE4 reserved address
         default: nfs_mask = `NFS_RESERVED_BYTE;
      endcase
   endfunction

   function automatic logic [7:0] nfs_len(input nfs_pkg::nfs_state_t st, input logic phase);
      case (st)
         nfs_pkg::NFS_POR: nfs_len = 8'(`NFS_WB_CYC);
         nfs_pkg::NFS_ADL: nfs_len = 8'(`NFS_ADL_CYC);
         nfs_pkg::NFS_WB: nfs_len = 8'(`NFS_WB_CYC);
         nfs_pkg::NFS_RD: nfs_len = phase ? 8'(`NFS_STROBE_CYC) : 8'(`NFS_RD_LOW_CYC);
         default: nfs_len = 8'(`NFS_STROBE_CYC);
      endcase
   endfunction

   nfs_timer u_timer (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .load(s_reg.tmr_load),
      .len(s_reg.tmr_len),
      .done(tmr_done)
   );

   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      case (s_reg.st)
         nfs_pkg::NFS_POR: begin
            // RULE18 reset command goes out first
            if (tmr_done) begin
               s_next.st = nfs_pkg::NFS_RST;
            end
         end
         nfs_pkg::NFS_IDLE: begin
            // RULE8 start only while the target is ready
            if (START && s_reg.ready && RB_N) begin
               s_next.st = nfs_pkg::NFS_CMD;
               s_next.get = GET;
               s_next.addr = FEAT_ADDR;
               // RULE19 reserved bits cleared
               s_next.p1 = nfs_mask(FEAT_ADDR, PARAM1);
               s_next.rdata = 32'h00000000;
               s_next.idx = 2'h0;
            end
         end
         nfs_pkg::NFS_RST, nfs_pkg::NFS_CMD, nfs_pkg::NFS_ADR, nfs_pkg::NFS_PAR: begin
            if (tmr_done) begin
               if (!s_reg.phase) begin
                  // RULE10 rising write strobe latches the byte
                  s_next.phase = 1'b1;
               end else begin
                  s_next.phase = 1'b0;
                  case (s_reg.st)
                     nfs_pkg::NFS_RST: s_next.st = nfs_pkg::NFS_WB;
                     nfs_pkg::NFS_CMD: s_next.st = nfs_pkg::NFS_ADR;
                     // RULE14 get waits busy right after the address
                     nfs_pkg::NFS_ADR: s_next.st = s_reg.get ? nfs_pkg::NFS_WB : nfs_pkg::NFS_ADL;
                     default: begin
                        // RULE11 busy wait after the fourth byte
                        if (s_reg.idx == 2'h3) begin
                           s_next.st = nfs_pkg::NFS_WB;
                        end else begin
                           s_next.idx = s_reg.idx + 2'h1;
                        end
                     end
                  endcase
               end
            end
         end
         nfs_pkg::NFS_ADL: begin
            // RULE10 address-to-param delay
            if (tmr_done) begin
               s_next.st = nfs_pkg::NFS_PAR;
               s_next.idx = 2'h0;
            end
         end
         nfs_pkg::NFS_WB: begin
            if (tmr_done) begin
               s_next.st = nfs_pkg::NFS_RDY;
            end
         end
         nfs_pkg::NFS_RDY: begin
            // RULE12 ready pin also covers the interface change time
            if (RB_N) begin
               s_next.idx = 2'h0;
               if (s_reg.init) begin
                  s_next.st = nfs_pkg::NFS_IDLE;
                  s_next.init = 1'b0;
               end else if (s_reg.get) begin
                  s_next.st = nfs_pkg::NFS_RD;
                  s_next.phase = 1'b0;
               end else begin
                  s_next.st = nfs_pkg::NFS_IDLE;
                  s_next.done = 1'b1;
               end
            end
         end
         nfs_pkg::NFS_RD: begin
            // RULE15 four bytes in order, first byte ends lowest
            if (tmr_done) begin
               if (!s_reg.phase) begin
                  s_next.phase = 1'b1;
                  s_next.rdata = {IO_IN, s_reg.rdata[31:8]};
               end else begin
                  s_next.phase = 1'b0;
                  if (s_reg.idx == 2'h3) begin
                     s_next.st = nfs_pkg::NFS_IDLE;
                     s_next.done = 1'b1;
                  end else begin
                     s_next.idx = s_reg.idx + 2'h1;
                  end
               end
            end
         end
         default: begin
            s_next.st = nfs_pkg::NFS_POR;
         end
      endcase

      // pins follow the next state so they leave straight from flops
      wr_state = (s_next.st == nfs_pkg::NFS_RST) || (s_next.st == nfs_pkg::NFS_CMD) ||
                 (s_next.st == nfs_pkg::NFS_ADR) || (s_next.st == nfs_pkg::NFS_PAR);
      s_next.ce_n = (s_next.st == nfs_pkg::NFS_IDLE) || (s_next.st == nfs_pkg::NFS_POR);
      s_next.we_n = !(wr_state && !s_next.phase);
      s_next.oe_n = !wr_state;
      s_next.cle = (s_next.st == nfs_pkg::NFS_RST) || (s_next.st == nfs_pkg::NFS_CMD);
      s_next.ale = (s_next.st == nfs_pkg::NFS_ADR);
      s_next.re_n = !((s_next.st == nfs_pkg::NFS_RD) && !s_next.phase);
      case (s_next.st)
         // RULE3 only a soft reset, stored settings stay
         nfs_pkg::NFS_RST: s_next.io_out = `NFS_CMD_RESET;
         // RULE9 set code, RULE13 get code
         nfs_pkg::NFS_CMD: s_next.io_out = s_next.get ? `NFS_CMD_GETF : `NFS_CMD_SETF;
         nfs_pkg::NFS_ADR: s_next.io_out = s_next.addr;
         // RULE6 only the first byte carries data
         nfs_pkg::NFS_PAR: s_next.io_out = (s_next.idx == 2'h0) ? s_next.p1 : `NFS_RESERVED_BYTE;
         default: s_next.io_out = 8'h00;
      endcase
      s_next.tmr_load = (s_next.st != s_reg.st) || (s_next.phase != s_reg.phase);
      s_next.tmr_len = nfs_len(s_next.st, s_next.phase);
      s_next.ready = (s_next.st == nfs_pkg::NFS_IDLE) && RB_N && !s_next.done;
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         s_reg <= '{st: nfs_pkg::NFS_POR, phase: 1'b0, idx: 2'h0, get: 1'b0, init: 1'b1,
                    addr: 8'h00, p1: 8'h00, rdata: 32'h00000000, tmr_load: 1'b1,
                    tmr_len: 8'(`NFS_WB_CYC), ready: 1'b0, done: 1'b0, ce_n: 1'b1,
                    cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io_out: 8'h00, oe_n: 1'b1};
      end else begin
         s_reg <= s_next;
      end
   end

   assign READY = s_reg.ready;
   assign DONE = s_reg.done;
   assign RDATA = s_reg.rdata;
   assign CE_N = s_reg.ce_n;
   assign CLE = s_reg.cle;
   assign ALE = s_reg.ale;
   assign WE_N = s_reg.we_n;
   assign RE_N = s_reg.re_n;
   assign IO_OUT = s_reg.io_out;
   assign IO_OE_N = s_reg.oe_n;
   assign in_adl = (s_reg.st == nfs_pkg::NFS_ADL);

   localparam int ADL_CYC = `NFS_ADL_CYC;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);

   sequence strobe_low3;
      !WE_N [*3];
   endsequence

   a_cmd_code: assert property (($rose(WE_N) && CLE) |->
      (IO_OUT == `NFS_CMD_SETF || IO_OUT == `NFS_CMD_GETF || IO_OUT == `NFS_CMD_RESET)) // RULE1
      else $error("bad command byte latched");
   a_get_mode: assert property (!RE_N |-> s_reg.get) // RULE2
      else $error("read strobe outside get-features");
   a_addr_byte: assert property (($rose(WE_N) && ALE) |-> (IO_OUT == s_reg.addr && !CLE)) // RULE4
      else $error("address byte wrong");
   a_adl_gap: assert property ((s_reg.st == nfs_pkg::NFS_PAR && $past(in_adl)) |-> $past(in_adl, ADL_CYC)) // RULE10
      else $error("address-to-param delay too short");
   a_strobe_width: assert property ($fell(WE_N) |-> strobe_low3 ##1 IO_OE_N == 1'b0) // RULE10
      else $error("write strobe too short or bus released");
   a_four_params: assert property ((s_reg.st == nfs_pkg::NFS_PAR && s_next.st == nfs_pkg::NFS_WB) |->
      s_reg.idx == 2'h3) // RULE11
      else $error("busy wait before fourth parameter");
   a_start_ready: assert property (($fell(CE_N) && IO_OUT != `NFS_CMD_RESET) |-> $past(READY) && $past(RB_N)) // RULE8
      else $error("command issued while target busy");
   a_reserved_zero: assert property (($rose(WE_N) && s_reg.st == nfs_pkg::NFS_PAR && s_reg.idx != 2'h0) |->
      IO_OUT == `NFS_RESERVED_BYTE) // RULE19
      else $error("reserved parameter not zero");
   a_done_ready: assert property (DONE |-> $past(RB_N) && s_reg.st == nfs_pkg::NFS_IDLE) // RULE14
      else $error("done before target ready");

endmodule

// ===== src/nfs_regs.svh
// constants for the feature-parameter host controller
`ifndef NFS_REGS_SVH
`define NFS_REGS_SVH

`define NFS_CLK_NS 4

`define NFS_CMD_SETF 8'hef
`define NFS_CMD_GETF 8'hee
`define NFS_CMD_RESET 8'hff

`define NFS_FA_TIMING 8'h01
`define NFS_FA_DRIVE 8'h80
`define NFS_FA_PULLDN 8'h81
`define NFS_FA_ARRAY 8'h90

`define NFS_TIMING_MASK 8'h07
`define NFS_DRIVE_MASK 8'h03
`define NFS_PULLDN_MASK 8'h03
`define NFS_ARRAY_MASK 8'h0b
`define NFS_TIMING_RST 8'h00
`define NFS_DRIVE_RST 8'h00
`define NFS_ARRAY_RST 8'h00
`define NFS_ARRAY_ECC_ON 8'h08
`define NFS_RESERVED_BYTE 8'h00

`define NFS_STROBE_NS 12
`define NFS_RD_LOW_NS 24
`define NFS_ADL_NS 70
`define NFS_WB_NS 100

`define NFS_CEIL_CYC(ns) (((ns) + `NFS_CLK_NS - 1) / `NFS_CLK_NS)
`define NFS_STROBE_CYC `NFS_CEIL_CYC(`NFS_STROBE_NS)
`define NFS_RD_LOW_CYC `NFS_CEIL_CYC(`NFS_RD_LOW_NS)
`define NFS_ADL_CYC `NFS_CEIL_CYC(`NFS_ADL_NS)
`define NFS_WB_CYC `NFS_CEIL_CYC(`NFS_WB_NS)

`endif

// ===== src/nfs_pkg.sv
// types of the feature-parameter host controller
package nfs_pkg;

   typedef enum logic [9:0] {
      NFS_POR = 10'b0000000001,
      NFS_IDLE = 10'b0000000010,
      NFS_RST = 10'b0000000100,
      NFS_CMD = 10'b0000001000,
      NFS_ADR = 10'b0000010000,
      NFS_ADL = 10'b0000100000,
      NFS_PAR = 10'b0001000000,
      NFS_WB = 10'b0010000000,
      NFS_RDY = 10'b0100000000,
      NFS_RD = 10'b1000000000
   } nfs_state_t;

   typedef struct packed {
      nfs_state_t st;
      logic phase;
      logic [1:0] idx;
      logic get;
      logic init;
      logic [7:0] addr;
      logic [7:0] p1;
      logic [31:0] rdata;
      logic tmr_load;
      logic [7:0] tmr_len;
      logic ready;
      logic done;
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic re_n;
      logic [7:0] io_out;
      logic oe_n;
   } nfs_host_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic fire;
   } nfs_timer_t;

endpackage

// ===== src/nfs_timer.sv
// one-shot cycle timer giving a done pulse after a loaded length
`timescale 1ns/1ns
module nfs_timer (
   input wire logic clk,         // reference clock
   input wire logic rst_n,       // synchronous reset, active low
   input wire logic load,        // start a new count
   input wire logic [7:0] len,   // count length in cycles
   output logic done             // one-cycle pulse at the end
);

   nfs_pkg::nfs_timer_t t_reg;
   nfs_pkg::nfs_timer_t t_next;

   always_comb begin
      t_next = t_reg;
      t_next.fire = 1'b0;
      if (load) begin
         t_next.cnt = len;
      end else if (t_reg.cnt != 8'h00) begin
         t_next.cnt = t_reg.cnt - 8'h01;
         t_next.fire = (t_reg.cnt == 8'h01);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         t_reg <= '0;
      end else begin
         t_reg <= t_next;
      end
   end

   assign done = t_reg.fire;

endmodule

// ===== src/dummy_unused_guard.sv
// no logic lives in this file

// ===== tb/nfs_dev_model.sv
// behavioural nand target holding the feature registers
`timescale 1ns/1ns
`include "nfs_regs.svh"
module nfs_dev_model (
   input wire logic clk,            // bench clock, rb_n decoded from a register, io_in follows re_n directly
   input wire logic por_n,          // power on, low clears settings
   input wire logic ce_n,           // chip enable, active low
   input wire logic cle,            // command latch enable
   input wire logic ale,            // address latch enable
   input wire logic we_n,           // write strobe, active low
   input wire logic re_n,           // read strobe, active low
   input wire logic [7:0] io_out,   // host bus value
   input wire logic io_oe_n,        // host drives bus when low
   input wire logic [7:0] busy_len, // busy length in cycles
   output logic [7:0] io_in,        // bus value seen by host
   output logic rb_n                // ready high, busy low
);
   logic [7:0] timing_mode_setting, output_drive_setting, array_operation_setting;
   logic [7:0] cmd_reg, addr_reg, p1_reg, busy, adl_run, adl_cyc, rbyte;
   logic [2:0] pcnt;
   logic [1:0] ridx;
   logic we_q, re_q;
   // first command after power-up, to see the reset goes out first
   logic [7:0] first_cmd;
   logic got_cmd;
   assign rbyte = (ridx != 2'd0 || cmd_reg != `NFS_CMD_GETF) ? 8'h00 :
      (addr_reg == `NFS_FA_TIMING) ? timing_mode_setting :
      (addr_reg == `NFS_FA_DRIVE) ? output_drive_setting :
      (addr_reg == `NFS_FA_ARRAY) ? array_operation_setting : 8'h00;
   // released bus shows the inverse, never a stale byte
   assign io_in = re_n ? ~rbyte : rbyte;
   assign rb_n = (busy == 8'h00);
   always_ff @(posedge clk) begin
      we_q <= we_n;
      re_q <= re_n;
      if (busy != 8'h00) busy <= busy - 8'h01;
      if (adl_run != 8'hff) adl_run <= adl_run + 8'h01;
      if (!por_n) begin
         timing_mode_setting <= 8'h00;
         output_drive_setting <= 8'h00;
         array_operation_setting <= 8'h00;
         cmd_reg <= 8'h00;
         busy <= 8'h00;
         pcnt <= 3'd0;
         ridx <= 2'd0;
         got_cmd <= 1'b0;
      end else if (!ce_n && !we_q && we_n && !io_oe_n && busy == 8'h00) begin
         if (cle) begin
            cmd_reg <= io_out;
            pcnt <= 3'd0;
            ridx <= 2'd0;
            if (io_out == `NFS_CMD_RESET) busy <= busy_len;
            got_cmd <= 1'b1;
            if (!got_cmd) first_cmd <= io_out;
         end else if (ale) begin
            addr_reg <= io_out;
            adl_run <= 8'h00;
            if (cmd_reg == `NFS_CMD_GETF) busy <= busy_len;
         end else if (cmd_reg == `NFS_CMD_SETF && pcnt < 3'd4) begin
            pcnt <= pcnt + 3'd1;
            if (pcnt == 3'd0) adl_cyc <= adl_run;
            if (pcnt == 3'd0) p1_reg <= io_out;
            if (pcnt == 3'd3) begin
               busy <= busy_len;
               if (addr_reg == `NFS_FA_TIMING) timing_mode_setting <= p1_reg;
               if (addr_reg == `NFS_FA_DRIVE) output_drive_setting <= p1_reg;
               if (addr_reg == `NFS_FA_ARRAY) array_operation_setting <= p1_reg;
            end
         end
      end else if (!ce_n && !re_q && re_n) begin
         ridx <= ridx + 2'd1;
      end
   end
endmodule

// ===== tb/test_nand_feature_set_get.sv
// self-checking bench for the feature host controller
`timescale 1ns/1ns
`include "nfs_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("Error %s exp %h got %h", nm, e, g); end end
module test_nand_feature_set_get;
   logic REF_CLK = 1'b0, RST_N = 1'b0, START = 1'b0, GET = 1'b0, por_n = 1'b0;
   logic [7:0] FEAT_ADDR = 8'h00, PARAM1 = 8'h00, busy_len = 8'h00, IO_OUT, IO_IN;
   logic READY, DONE, CE_N, CLE, ALE, WE_N, RE_N, IO_OE_N, RB_N;
   logic [31:0] RDATA;
   int errors = 0, n_compared = 0, cyc = 0, n_w = 0;
   nfs_host u_nfs_host (.REF_CLK(REF_CLK), .RST_N(RST_N), .START(START), .GET(GET), .FEAT_ADDR(FEAT_ADDR),
      .PARAM1(PARAM1), .READY(READY), .DONE(DONE), .RDATA(RDATA), .CE_N(CE_N), .CLE(CLE), .ALE(ALE),
      .WE_N(WE_N), .RE_N(RE_N), .IO_OUT(IO_OUT), .IO_IN(IO_IN), .IO_OE_N(IO_OE_N), .RB_N(RB_N));
   nfs_dev_model u_nfs_dev_model (.clk(REF_CLK), .por_n(por_n), .ce_n(CE_N), .cle(CLE), .ale(ALE),
      .we_n(WE_N), .re_n(RE_N), .io_out(IO_OUT), .io_oe_n(IO_OE_N), .busy_len(busy_len), .io_in(IO_IN),
      .rb_n(RB_N));
   initial forever #2 REF_CLK = ~REF_CLK;
   // whole run is about 20 ops of about a hundred cycles each, the two slow-busy ops a few hundred each
   always @(posedge REF_CLK) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic do_op(input logic g, input logic [7:0] a, input logic [7:0] p, input bit poke);
      int n;
      n = 0;
      while (READY !== 1'b1 && n < 4000) begin
         @(negedge REF_CLK);
         n++;
      end
      `CHK("ready_wait", 1'b1, READY)
      START = 1'b1;
      GET = g;
      FEAT_ADDR = a;
      PARAM1 = p;
      @(negedge REF_CLK);
      START = 1'b0;
      n = 0;
      while (DONE !== 1'b1 && n < 20000) begin
         @(negedge REF_CLK);
         n++;
         // a request while busy must be ignored
         if (poke && n == 40) begin
            START = 1'b1;
            GET = ~g;
            FEAT_ADDR = `NFS_FA_TIMING;
         end
         if (n == 41) START = 1'b0;
      end
      n_w = n;
      `CHK("done_seen", 1'b1, DONE)
      `CHK("rb_at_done", 1'b1, RB_N)
   endtask
   task automatic set_get(input logic [7:0] a, input logic [7:0] p, input logic [7:0] e);
      do_op(1'b0, a, p, 1'b0);
      `CHK("param_count", 3'd4, u_nfs_dev_model.pcnt)
      `CHK("adl_ok", 1'b1, u_nfs_dev_model.adl_cyc >= 8'd18)
      do_op(1'b1, a, 8'h00, 1'b0);
      `CHK("rdata", {24'h000000, e}, RDATA)
   endtask
   task automatic t_init();
      do_op(1'b1, `NFS_FA_ARRAY, 8'h00, 1'b0);
      `CHK("first_cmd_reset", `NFS_CMD_RESET, u_nfs_dev_model.first_cmd)
      `CHK("array_reset", 32'h00000000, RDATA)
   endtask
   task automatic t_table();
      logic [7:0] ta [7] = '{8'h01, 8'h01, 8'h80, 8'h90, 8'h90, 8'h90, 8'h42};
      logic [7:0] tp [7] = '{8'h05, 8'hff, 8'h02, 8'h08, 8'hff, 8'h00, 8'hff};
      logic [7:0] te [7] = '{8'h05, 8'h07, 8'h02, 8'h08, 8'h0b, 8'h00, 8'h00};
      for (int i = 0; i < 7; i++) set_get(ta[i], tp[i], te[i]);
   endtask
   task automatic t_slow();
      busy_len = 8'd200;
      do_op(1'b0, `NFS_FA_DRIVE, 8'h01, 1'b1);
      `CHK("slow_wait", 1'b1, n_w >= 200)
      `CHK("drive_set", 8'h01, u_nfs_dev_model.output_drive_setting)
      do_op(1'b1, `NFS_FA_DRIVE, 8'h00, 1'b0);
      `CHK("slow_get", 32'h00000001, RDATA)
      busy_len = 8'd0;
   endtask
   task automatic t_resets();
      set_get(`NFS_FA_TIMING, 8'h03, 8'h03);
      RST_N = 1'b0;
      repeat (8) @(negedge REF_CLK);
      RST_N = 1'b1;
      do_op(1'b1, `NFS_FA_TIMING, 8'h00, 1'b0);
      `CHK("soft_reset_keep", 32'h00000003, RDATA)
      por_n = 1'b0;
      RST_N = 1'b0;
      repeat (8) @(negedge REF_CLK);
      por_n = 1'b1;
      RST_N = 1'b1;
      do_op(1'b1, `NFS_FA_TIMING, 8'h00, 1'b0);
      `CHK("power_default", 32'h00000000, RDATA)
      `CHK("por_first_reset", `NFS_CMD_RESET, u_nfs_dev_model.first_cmd)
   endtask
   initial begin
      busy_len = 8'd10;
      repeat (8) @(negedge REF_CLK);
      por_n = 1'b1;
      RST_N = 1'b1;
      t_init();
      busy_len = 8'd0;
      t_table();
      t_slow();
      t_resets();
      finish_test();
   end
endmodule
